/* rtl/poi_option_irq.v */
// poi_option_irq.v: processor option internal interrupt unit
// assumes memory, temp register and sequencer on clk; power and straps are async
//
// Overview of operation
// - check parity on every read; error sets flag 4 and status 4
// - store an even parity bit per byte, generated on writes
// - access to a missing module sets flag 4 and status 5
// - up to 32 protect areas sized 256, 512 or 1024 bytes
// - 32-bit protect map; command 1740 copies temp bit 7 to addressed area
// - map bit one means protected, zero unprotected
// - violation turns write into read-restore; sets flag 4 and status 3
// - block writes to protected area from unprotected instruction fetches
// - block writes from unprotected byte I/O or DMA peripherals
// - allow protected instructions and protected peripherals to write
// - spare bit widens memory, temp and I/O bus to nine bits only
// - spare bit loads from load-temp bit 11; 1702 clears, 1F02 sets
// - real-time tick divides the clock by strap value below 2^13
// - each tick sets flag 4 and status 2
// - command 1710 disables, 1720 enables the clock interrupt
// - primary power loss raises interrupt and sets status 7
// - hold machine in reset once halted after power loss
// - hold machine reset for 200 ms after power applied
// - switch to run mode when power-on reset ends
// - raise power-fail interrupt right after automatic run
// - power-on reset clears microprogram location register
// - machine reset clears I/O control and halts; offered to I/O devices
`timescale 1ns/1ps
`include "poi_regs.vh"
module poi_option_irq #(
	parameter POR_CYCLES = `POI_POR_CYCLES,
	parameter AW         = 16
) (
	// clock and reset
	input  wire          clk,
	input  wire          rst,
	// microcommand from sequencer
	input  wire          cmd_valid,
	input  wire [15:0]   cmd_word,
	input  wire          loadt_valid,
	input  wire [15:0]   loadt_word,
	input  wire [7:0]    temp_low,
	// memory cycle
	input  wire          mem_req,
	input  wire          mem_write,
	input  wire [AW-1:0] mem_addr,
	input  wire [8:0]    mem_wdata,
	input  wire [8:0]    mem_rdata,
	input  wire          mem_rpar,
	input  wire          mem_rvalid,
	input  wire [3:0]    mod_present,
	input  wire [1:0]    mem_size,
	input  wire          fetch_req,
	input  wire          src_periph,
	input  wire          periph_prot,
	// memory control out
	output reg           mem_write_ok,
	output reg           mem_wpar,
	// spare temp bit
	output reg           temp_spare_ff,
	// interrupt flag and status
	input  wire [7:0]    status_clr,
	input  wire          flag_clr,
	output reg  [7:0]    int_status_ff,
	output reg           cond_flag_ff,
	// power and straps (async)
	input  wire          power_ok,
	input  wire          cpu_halted,
	input  wire [12:0]   rtc_strap,
	// machine control
	output reg           mach_reset_ff,
	output reg           run_req_ff,
	output reg           loc_clear_ff
);
	// protect map and fetch-origin state
	reg  [31:0]   prot_map_ff;
	reg           fetch_prot_ff;
	reg           rtc_en_ff;
	reg  [12:0]   rtc_cnt_ff;
	reg  [31:0]   por_cnt_ff;
	reg  [1:0]    por_st_ff;
	reg           pf_seen_ff;
	// synchronisers
	reg  [1:0]    pwr_sync_ff;
	reg  [12:0]   strap_s1_ff;
	reg  [12:0]   strap_s2_ff;
	reg           pwr_d_ff;
	wire          pwr_ok_s = pwr_sync_ff[1];

	localparam POR_HOLD = 2'h0;
	localparam POR_RUN  = 2'h1;
	localparam POR_IRQ  = 2'h2;
	localparam POR_IDLE = 2'h3;

	// area index of an address for the installed memory size
	function [4:0] area_of;
		input [AW-1:0] a;
		input [1:0]    sz;
		begin
			case (sz)
				`POI_AREA_256:  area_of = a[12:8];
				`POI_AREA_512:  area_of = a[13:9];
				`POI_AREA_1024: area_of = a[14:10];
				default:        area_of = a[12:8];
			endcase
		end
	endfunction

	// one microcommand match, shared by every decoded command
	function is_cmd;
		input [15:0] w;
		input [15:0] code;
		begin
			is_cmd = (w == code);
		end
	endfunction

	// parity check on read data, generation on write data
	wire par_err;
	wire par_gen_r;
	wire par_gen_w;
	poi_parity #(.W(9)) u_rpar (
		.data    (mem_rdata),
		.par_in  (mem_rpar),
		.par_gen (par_gen_r),
		.par_err (par_err)
	);
	poi_parity #(.W(9)) u_wpar (
		.data    (mem_wdata),
		.par_in  (1'b0),
		.par_gen (par_gen_w),
		.par_err ()
	);

	// module decode: four 16 KB modules across the address space
	wire [1:0] mod_idx  = mem_addr[AW-1:AW-2];
	wire       bound_ev = mem_req & ~mod_present[mod_idx];
	wire [4:0] area     = area_of(mem_addr, mem_size);
	wire       area_pr  = prot_map_ff[area];
	wire       writer_pr = src_periph ? periph_prot : fetch_prot_ff;
	// a missing module takes precedence, so one access flags only one cause
	wire       viol_ev  = mem_req & mem_write & ~bound_ev & area_pr
		& ~writer_pr;
	wire       parity_ev = mem_rvalid & par_err;

	// write gating: violation turns write into read-restore
	always @* begin
		mem_write_ok = mem_req & mem_write & ~viol_ev & ~bound_ev;
		mem_wpar     = par_gen_w;
	end

	// command decode
	wire cmd_prot  = cmd_valid & is_cmd(cmd_word, `POI_CMD_PROT_LOAD);
	wire cmd_rtoff = cmd_valid & is_cmd(cmd_word, `POI_CMD_RTC_OFF);
	wire cmd_rton  = cmd_valid & is_cmd(cmd_word, `POI_CMD_RTC_ON);
	wire cmd_sclr  = cmd_valid & is_cmd(cmd_word, `POI_CMD_SPARE_CLR);
	wire cmd_sset  = cmd_valid & is_cmd(cmd_word, `POI_CMD_SPARE_SET);

	// protect map load and fetch origin tracking
	// origin follows the last fetch; reset leaves it unprotected, the safe side
	always @(posedge clk) begin
		if (rst) begin
			prot_map_ff   <= 32'h00000000;
			fetch_prot_ff <= 1'b0;
		end else begin
			if (cmd_prot)
				prot_map_ff[area] <= temp_low[7];
			if (mem_req & fetch_req)
				fetch_prot_ff <= area_pr;
		end
	end

	// spare temp bit; it feeds only memory, temp and the I/O bus
	always @(posedge clk) begin
		if (rst)
			temp_spare_ff <= 1'b0;
		else if (loadt_valid)
			temp_spare_ff <= loadt_word[`POI_LOADT_SPARE];
		else if (cmd_sclr)
			temp_spare_ff <= 1'b0;
		else if (cmd_sset)
			temp_spare_ff <= 1'b1;
	end

	// async input synchronisers; strap is quasi-static
	// straps are set at install time, so a plain two-stage copy of the bus is enough
	always @(posedge clk) begin
		if (rst) begin
			pwr_sync_ff <= 2'h0;
			strap_s1_ff <= 13'h0000;
			strap_s2_ff <= 13'h0000;
			pwr_d_ff    <= 1'b0;
		end else begin
			pwr_sync_ff <= {pwr_sync_ff[0], power_ok};
			strap_s1_ff <= rtc_strap;
			strap_s2_ff <= strap_s1_ff;
			pwr_d_ff    <= pwr_ok_s;
		end
	end

	// real-time divider: a strap of zero or one ticks every cycle
	// limitation: a new strap value is only picked up at the next reload
	wire rtc_tick = (rtc_cnt_ff == 13'h0000);
	always @(posedge clk) begin
		if (rst) begin
			rtc_cnt_ff <= 13'h0000;
			rtc_en_ff  <= 1'b0;
		end else begin
			if (rtc_tick)
				rtc_cnt_ff <= (strap_s2_ff == 13'h0000) ? 13'h0000
					: strap_s2_ff - 13'h0001;
			else
				rtc_cnt_ff <= rtc_cnt_ff - 13'h0001;
			if (cmd_rtoff)
				rtc_en_ff <= 1'b0;
			else if (cmd_rton)
				rtc_en_ff <= 1'b1;
		end
	end

	// power-on sequence: hold reset, go to run, then raise restart irq
	wire pf_fall = pwr_d_ff & ~pwr_ok_s;
	reg  pf_irq;
	always @(posedge clk) begin
		if (rst) begin
			por_st_ff     <= POR_HOLD;
			por_cnt_ff    <= 32'h00000000;
			mach_reset_ff <= 1'b1;
			run_req_ff    <= 1'b0;
			loc_clear_ff  <= 1'b1;
			pf_seen_ff    <= 1'b0;
		end else begin
			run_req_ff   <= 1'b0;
			loc_clear_ff <= 1'b0;
			if (pf_fall)
				pf_seen_ff <= 1'b1;
			case (por_st_ff)
				POR_HOLD: begin
					mach_reset_ff <= 1'b1;
					loc_clear_ff  <= 1'b1;
					// a dip seen while held is already covered by this hold
					pf_seen_ff    <= 1'b0;
					// a power dip during hold restarts the full count
					if (!pwr_ok_s)
						por_cnt_ff <= 32'h00000000;
					else if (por_cnt_ff >= POR_CYCLES - 1) begin
						por_st_ff     <= POR_RUN;
						mach_reset_ff <= 1'b0;
					end else
						por_cnt_ff <= por_cnt_ff + 32'h00000001;
				end
				POR_RUN: begin
					run_req_ff <= 1'b1;
					por_st_ff  <= POR_IRQ;
				end
				POR_IRQ: begin
					por_st_ff <= POR_IDLE;
				end
				POR_IDLE: begin
					if (pf_seen_ff & cpu_halted) begin
						mach_reset_ff <= 1'b1;
						pf_seen_ff    <= 1'b0;
						por_cnt_ff    <= 32'h00000000;
						por_st_ff     <= POR_HOLD;
					end
				end
				default: por_st_ff <= POR_HOLD;
			endcase
		end
	end

	always @* begin
		pf_irq = pf_fall | (por_st_ff == POR_IRQ);
	end

	// sticky status and condition flag: set wins over clear
	// one bit per source lets the microprogram tell causes apart
	reg [7:0] nxt_status;
	always @* begin
		nxt_status = int_status_ff & ~status_clr;
		if (parity_ev)
			nxt_status[`POI_ST_PARITY] = 1'b1;
		if (bound_ev)
			nxt_status[`POI_ST_BOUNDARY] = 1'b1;
		if (viol_ev)
			nxt_status[`POI_ST_PROTECT] = 1'b1;
		if (rtc_tick & rtc_en_ff)
			nxt_status[`POI_ST_RTC_BIT] = 1'b1;
		if (pf_irq)
			nxt_status[`POI_ST_POWER] = 1'b1;
	end

	wire any_ev = parity_ev | bound_ev | viol_ev | (rtc_tick & rtc_en_ff) | pf_irq;

	// status survives machine reset so restart can see the power bit
	always @(posedge clk) begin
		if (rst) begin
			int_status_ff <= 8'h00;
			cond_flag_ff  <= 1'b0;
		end else begin
			int_status_ff <= nxt_status;
			cond_flag_ff  <= any_ev | (cond_flag_ff & ~flag_clr);
		end
	end
endmodule // poi_option_irq

/* rtl/poi_regs.vh */
// poi_regs.vh: constants for the processor option interrupt unit
// assumes the including file is plain Verilog-2005
`ifndef POI_REGS_VH
`define POI_REGS_VH
// internal status bit positions
`define POI_ST_PROTECT    3
`define POI_ST_RTC_BIT    2
`define POI_ST_PARITY     4
`define POI_ST_BOUNDARY   5
`define POI_ST_POWER      7
// condition flag bit raised by every internal interrupt
`define POI_CF_INTERNAL   4
// microcommand codes
`define POI_CMD_PROT_LOAD 16'h1740
`define POI_CMD_RTC_OFF   16'h1710
`define POI_CMD_RTC_ON    16'h1720
`define POI_CMD_SPARE_CLR 16'h1702
`define POI_CMD_SPARE_SET 16'h1F02
`define POI_CMD_LOADT_HI  4'h1
// spare bit source in a load-temp word
`define POI_LOADT_SPARE   11
// memory size codes for protect area size
`define POI_AREA_256      2'h0
`define POI_AREA_512      2'h1
`define POI_AREA_1024     2'h2
// power-on reset time and clock
`define POI_CLK_MHZ       50
`define POI_POR_MS        200
`define POI_POR_CYCLES    (`POI_POR_MS * 1000 * `POI_CLK_MHZ)
`define POI_RTC_DIV_W     13
`endif

/* rtl/poi_parity.v */
// poi_parity.v: even parity generator and checker for one memory byte
// assumes purely combinational use on the processor clock domain
`timescale 1ns/1ps
module poi_parity #(
	parameter W = 9
) (
	// data and stored parity
	input  wire [W-1:0] data,
	input  wire         par_in,
	// generated bit and check result
	output wire         par_gen,
	output wire         par_err
);
	// even parity: the stored bit makes the total count of ones even
	assign par_gen = ^data;
	assign par_err = par_gen ^ par_in;
endmodule // poi_parity

/* sim/poi_assertions.sv */
// poi_assertions.sv: checker for the option interrupt unit
// assumes binding to poi_option_irq, seeing its ports only
`timescale 1ns/1ps
module poi_assertions #(parameter POR_CYCLES = 20, parameter AW = 16) (
	input wire logic clk, rst, cmd_valid, loadt_valid, mem_req, mem_write, mem_rpar,
	input wire logic mem_rvalid, mem_write_ok, mem_wpar, temp_spare_ff, flag_clr,
	input wire logic cond_flag_ff, run_req_ff,
	input wire logic [15:0] cmd_word, loadt_word,
	input wire logic [AW-1:0] mem_addr,
	input wire logic [8:0] mem_wdata, mem_rdata,
	input wire logic [3:0] mod_present,
	input wire logic [7:0] status_clr, int_status_ff
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// module decode uses the top two address bits
	wire gone = !mod_present[mem_addr[AW-1 -: 2]];
	a_parity_flag: assert property (
		mem_rvalid && ^{mem_rdata, mem_rpar} |=> int_status_ff[4] && cond_flag_ff)
		else $error("parity error missed");
	a_write_parity: assert property (
		mem_req && mem_write |-> !(^{mem_wdata, mem_wpar}))
		else $error("write parity odd");
	a_missing_module: assert property (
		mem_req && gone |-> !(mem_write && mem_write_ok) ##1 int_status_ff[5] && cond_flag_ff)
		else $error("missing module missed");
	a_violation_flag: assert property (
		mem_req && mem_write && !mem_write_ok && !gone |=> int_status_ff[3] && cond_flag_ff)
		else $error("violation not flagged");
	a_spare_load: assert property (
		loadt_valid |=> temp_spare_ff == $past(loadt_word[11]))
		else $error("spare load wrong");
	a_spare_ctrl: assert property (
		cmd_valid && !loadt_valid && (cmd_word == 16'h1702 || cmd_word == 16'h1F02)
		|=> temp_spare_ff == $past(cmd_word[11]))
		else $error("spare control wrong");
	a_status_sticky: assert property (
		1'b1 |=> !($past(int_status_ff & ~status_clr) & ~int_status_ff)
		&& (!$past(cond_flag_ff && !flag_clr) || cond_flag_ff))
		else $error("status bit lost");
	a_restart_irq: assert property (
		run_req_ff |=> !run_req_ff ##[0:2] int_status_ff[7] && cond_flag_ff)
		else $error("restart interrupt missed");
	// main scenarios reached
	cover property (run_req_ff);
	cover property (mem_req && mem_write && !mem_write_ok);
	cover property (mem_rvalid && ^{mem_rdata, mem_rpar});
endmodule // poi_assertions
bind poi_option_irq poi_assertions #(.POR_CYCLES(POR_CYCLES), .AW(AW)) u_chk (.*);

/* sim/poi_core_mem.sv */
// poi_core_mem.sv: core memory partner holding nine data bits and parity per byte
// assumes the unit's write permit and parity outputs on the same clock
`timescale 1ns/1ps
module poi_core_mem (
	input wire logic clk, mem_req, mem_write, mem_wpar, mem_write_ok, bad_par,
	input wire logic [15:0] mem_addr,
	input wire logic [8:0] mem_wdata,
	output logic [8:0] mem_rdata,
	output logic mem_rpar,
	output logic mem_rvalid = 1'b0
);
	// blank core reads as zero with even parity, so an unwritten fetch is clean
	logic [9:0] core [0:65535] = '{default: 10'h000};
	// reads answer one cycle later; off the answer the bus inverts its last value each cycle
	always @(posedge clk) begin
		mem_rvalid <= mem_req && !mem_write;
		if (mem_req && !mem_write)
			{mem_rpar, mem_rdata} <= core[mem_addr] ^ {bad_par, 9'h000};
		else
			{mem_rpar, mem_rdata} <= ~{mem_rpar, mem_rdata};
		// a refused write is a read-restore, so the stored byte stays
		if (mem_req && mem_write && mem_write_ok)
			core[mem_addr] <= {mem_wpar, mem_wdata};
	end
endmodule // poi_core_mem

/* sim/testbench.sv */
// testbench.sv: directed test of the option interrupt unit with a core memory model
// assumes a 50 MHz clock and the unit's synchronous active-high reset
`timescale 1ns/1ps
module testbench;
	logic clk = 0, rst = 1, cmd_valid = 0, loadt_valid = 0, mem_req = 0, mem_write = 0;
	logic fetch_req = 0, src_periph = 0, periph_prot = 0, flag_clr = 0, power_ok = 1;
	logic cpu_halted = 0, bad_par = 0, mem_wpar, mem_write_ok, temp_spare_ff, cond_flag_ff;
	logic mem_rpar, mem_rvalid, mach_reset_ff, run_req_ff, loc_clear_ff;
	logic [15:0] cmd_word = 16'h0000, loadt_word = 16'h0000, mem_addr = 16'h0000, a;
	logic [8:0] mem_wdata = 9'h000, mem_rdata;
	logic [7:0] temp_low = 8'h00, status_clr = 8'h00, int_status_ff;
	logic [3:0] mod_present = 4'hF;
	logic [1:0] mem_size = 2'h0;
	logic [12:0] rtc_strap = 13'h0005;
	int n_errors = 0, samples_checked = 0, n;
	// short power-on count keeps the run brief
	poi_option_irq #(.POR_CYCLES(20)) dut (.*);
	poi_core_mem mem (.*);
	initial forever #10 clk = ~clk;
	task conclude;
		$display("checked %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input logic [15:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// bounded wait: a status bit, 8 for the run pulse, 9 for machine reset
	task wt(input int b);
		n = 0;
		while ((b == 8 ? run_req_ff : b == 9 ? mach_reset_ff : int_status_ff[b]) !== 1'b1) begin
			@(negedge clk);
			n++;
			if (n > 200) begin
				n_errors++;
				conclude;
			end
		end
	endtask
	task cmd(input logic [15:0] w);
		@(negedge clk) {cmd_valid, cmd_word} = {1'b1, w};
		@(negedge clk) cmd_valid = 0;
	endtask
	task ldt(input logic [15:0] w);
		@(negedge clk) {loadt_valid, loadt_word} = {1'b1, w};
		@(negedge clk) loadt_valid = 0;
	endtask
	task prot(input logic [15:0] ad, input logic b);
		mem_addr = ad;
		temp_low = {b, 7'h00};
		cmd(16'h1740);
	endtask
	task clr;
		@(negedge clk) {status_clr, flag_clr} = 9'h1FF;
		@(negedge clk) {status_clr, flag_clr} = 9'h000;
	endtask
	// kind bits: write, fetch, peripheral, peripheral protected
	task acc(input logic [15:0] ad, input logic [3:0] k, input logic ok);
		@(negedge clk) begin
			{mem_req, mem_addr, mem_write, fetch_req, src_periph, periph_prot} = {1'b1, ad, k};
			mem_wdata = ad[8:0] ^ 9'h1A5;
		end
		#1 if (k[3]) chk(mem_write_ok, ok);
		@(negedge clk) mem_req = 0;
	endtask
	initial begin
		repeat (4) @(negedge clk);
		rst = 0;
		chk({mach_reset_ff, loc_clear_ff}, 2'h3);
		wt(8);
		chk(n >= 20, 1);
		wt(7);
		chk({mach_reset_ff, n <= 2}, 2'h1);
		clr;
		acc(16'h0010, 4'h8, 1);
		acc(16'h0010, 4'h0, 0);
		repeat (2) @(negedge clk);
		chk(int_status_ff, 8'h00);
		bad_par = 1;
		acc(16'h0010, 4'h0, 0);
		repeat (2) @(negedge clk);
		bad_par = 0;
		chk({cond_flag_ff, int_status_ff}, 9'h110);
		clr;
		mod_present = 4'h7;
		acc(16'hC000, 4'h8, 0);
		@(negedge clk) mod_present = 4'hF;
		chk({cond_flag_ff, int_status_ff}, 9'h120);
		// one pass per area size, probing both sides of the area 0/1 border
		for (int s = 0; s < 3; s++) begin
			mem_size = s[1:0];
			a = 16'h0100 << s;
			prot(a, 1);
			clr;
			acc(16'h0000, 4'h4, 0);
			acc(a, 4'h8, 0);
			acc(a - 1, 4'h8, 1);
			acc(a, 4'hA, 0);
			acc(a, 4'hB, 1);
			chk({cond_flag_ff, int_status_ff}, 9'h108);
			acc(a, 4'h4, 0);
			acc(a + 1, 4'h8, 1);
			prot(a, 0);
			acc(16'h0000, 4'h4, 0);
			acc(a, 4'h8, 1);
		end
		ldt(16'h1900);
		chk(temp_spare_ff, 1);
		cmd(16'h1702);
		chk(temp_spare_ff, 0);
		cmd(16'h1F02);
		chk(temp_spare_ff, 1);
		ldt(16'h1100);
		chk(temp_spare_ff, 0);
		clr;
		repeat (12) @(negedge clk);
		chk(int_status_ff[2], 0);
		cmd(16'h1720);
		wt(2);
		clr;
		wt(2);
		chk(n, 3);
		cmd(16'h1710);
		clr;
		repeat (12) @(negedge clk);
		chk(int_status_ff[2], 0);
		power_ok = 0;
		wt(7);
		chk({cond_flag_ff, n < 5}, 2'h3);
		cpu_halted = 1;
		wt(9);
		repeat (3) @(negedge clk);
		chk({mach_reset_ff, loc_clear_ff}, 2'h3);
		cpu_halted = 0;
		power_ok = 1;
		wt(8);
		chk(mach_reset_ff, 0);
		conclude;
	end
endmodule // testbench
